/* File: src/ifc_counter.sv */
// IF frequency counter: gate timer, 19-bit edge count, registers, interrupt
//
// The strobed register port was decided locally.
`default_nettype none
module ifc_counter
  import ifc_pkg::*;
#(
  parameter logic [31:0] GATE8_CYC = IFC_GATE8_CYC,
  parameter logic [31:0] GATE32_CYC = IFC_GATE32_CYC,
  parameter logic [31:0] GATE128_CYC = IFC_GATE128_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic fm_if_input_pin,
  input wire logic am_if_input_pin,
  input wire logic isr_start,
  output logic irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ifc_state_t state;
    logic count_done_flag;
    logic count_run_control;
    logic [1:0] gate_sel;
    logic [1:0] input_sel;
    logic [IFC_CNT_W-1:0] count;
    logic [31:0] gate_cnt;
    logic detect_status_bit;
    logic evt_stat;
    logic evt_mask;
    logic [7:0] rdata;
    logic irq;
  } ifc_st_t;

  ifc_st_t st_ff;
  ifc_st_t nxt_st;
  ifc_bus_req_t req;
  logic fm_rise;
  logic am_rise;
  logic sel_rise;
  logic [31:0] gate_len;
  logic gate_end;
  logic done_evt;
  logic [7:0] mode_view;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ----------------------------------------------------------------
  // Input pins
  // ----------------------------------------------------------------
  ifc_sync u_sync_fm
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(fm_if_input_pin),
    .rise(fm_rise)
  );
  ifc_sync u_sync_am
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(am_if_input_pin),
    .rise(am_rise)
  );

  always_comb
  begin
    // Upper select bit low disables both pins
    sel_rise = 1'b0;
    if (st_ff.input_sel[1])
      sel_rise = st_ff.input_sel[0] ? am_rise : fm_rise;
  end

  always_comb
  begin
    unique case (ifc_gate_t'(st_ff.gate_sel))
      IFC_GATE_8MS: gate_len = GATE8_CYC;
      IFC_GATE_32MS: gate_len = GATE32_CYC;
      IFC_GATE_128MS: gate_len = GATE128_CYC;
      IFC_GATE_SOFT: gate_len = '0;
    endcase
  end

  assign gate_end = (st_ff.state == IFC_ST_COUNT) && (st_ff.gate_sel != 2'(IFC_GATE_SOFT))
    && (st_ff.gate_cnt == gate_len - 32'h1);

  assign mode_view = {st_ff.count_done_flag, st_ff.count_run_control, 1'b0, 1'b0,
    st_ff.gate_sel, st_ff.input_sel};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    done_evt = 1'b0;
    nxt_st.rdata = 8'h00;
    // Counting interval
    unique case (st_ff.state)
      IFC_ST_IDLE:
      begin
        nxt_st.gate_cnt = '0;
      end
      IFC_ST_COUNT:
      begin
        nxt_st.gate_cnt = st_ff.gate_cnt + 32'h1;
        if (sel_rise)
          nxt_st.count = st_ff.count + 19'h1;
        if (gate_end)
        begin
          nxt_st.state = IFC_ST_IDLE;
          nxt_st.count_run_control = 1'b0;
          done_evt = 1'b1;
        end
      end
      default: nxt_st.state = IFC_ST_IDLE;
    endcase
    if (sel_rise)
      nxt_st.detect_status_bit = 1'b1;
    // Register reads; read side effects
    if (req.rd)
    begin
      unique case (req.addr)
        IFC_MODE_OFS:
        begin
          nxt_st.rdata = mode_view;
          nxt_st.count_done_flag = 1'b0;
        end
        IFC_CNT_HIGH_OFS:
        begin
          nxt_st.rdata = {4'h0, st_ff.detect_status_bit, st_ff.count[18:16]};
          nxt_st.detect_status_bit = sel_rise;
        end
        IFC_CNT_MID_OFS: nxt_st.rdata = st_ff.count[15:8];
        IFC_CNT_LOW_OFS: nxt_st.rdata = st_ff.count[7:0];
        IFC_IRQ_STAT_OFS: nxt_st.rdata = {7'h00, st_ff.evt_stat};
        IFC_IRQ_MASK_OFS: nxt_st.rdata = {7'h00, st_ff.evt_mask};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    if (isr_start)
      nxt_st.count_done_flag = 1'b0;
    // Register writes
    if (req.wr)
    begin
      unique case (req.addr)
        IFC_MODE_OFS:
        begin
          nxt_st.gate_sel = req.wdata[IFC_GATE_LSB +: 2];
          nxt_st.input_sel = req.wdata[IFC_INSEL_LSB +: 2];
          // Bit 4 ignored; software keeps it zero
          if (req.wdata[IFC_CLR_BIT])
          begin
            nxt_st.count = '0;
            // An edge in the clearing cycle still marks detect
            nxt_st.detect_status_bit = sel_rise;
          end
          nxt_st.count_run_control = req.wdata[IFC_RUN_BIT];
          // A start that meets the gate end opens a fresh interval
          if (req.wdata[IFC_RUN_BIT])
          begin
            nxt_st.state = IFC_ST_COUNT;
            if (st_ff.state == IFC_ST_IDLE || done_evt)
              nxt_st.gate_cnt = '0;
          end
          else if (!req.wdata[IFC_RUN_BIT])
          begin
            nxt_st.state = IFC_ST_IDLE;
            // Software gate ends on run clear
            if (st_ff.state == IFC_ST_COUNT && st_ff.gate_sel == 2'(IFC_GATE_SOFT))
              done_evt = 1'b1;
          end
        end
        IFC_IRQ_STAT_OFS:
          if (req.wdata[IFC_EVT_DONE_BIT])
            nxt_st.evt_stat = 1'b0;
        IFC_IRQ_MASK_OFS: nxt_st.evt_mask = req.wdata[IFC_EVT_DONE_BIT];
        default: ;
      endcase
    end
    // Set wins over every clear
    if (done_evt)
    begin
      nxt_st.count_done_flag = 1'b1;
      nxt_st.evt_stat = 1'b1;
    end
    nxt_st.irq = nxt_st.evt_stat & nxt_st.evt_mask;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.state <= IFC_ST_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign rdata = st_ff.rdata;
  assign irq = st_ff.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence run_write_s;
    wr && addr == IFC_MODE_OFS && wdata[IFC_RUN_BIT];
  endsequence

  sequence stop_write_s;
    wr && addr == IFC_MODE_OFS && !wdata[IFC_RUN_BIT];
  endsequence

  sequence mode_read_s;
    rd && addr == IFC_MODE_OFS;
  endsequence

  // A software-gated interval closed by a run clear
  sequence soft_stop_s;
    st_ff.state == IFC_ST_COUNT && st_ff.gate_sel == 2'h3 ##0 stop_write_s;
  endsequence

  // Done flag and interrupt status
  done_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gate_end |=> st_ff.count_done_flag)
    else $error("done flag not set at gate end");

  evt_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_evt |=> st_ff.evt_stat && st_ff.count_done_flag)
    else $error("interval end not recorded");

  done_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_read_s |=> rdata[IFC_DONE_BIT] == $past(st_ff.count_done_flag))
    else $error("done flag read wrong");

  done_rd_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd && addr == IFC_MODE_OFS && !done_evt |=> !st_ff.count_done_flag)
    else $error("done flag not cleared by read");

  done_isr_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isr_start && !done_evt |=> !st_ff.count_done_flag)
    else $error("done flag not cleared by service start");

  irq_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && addr == IFC_IRQ_STAT_OFS && wdata[IFC_EVT_DONE_BIT] && !done_evt |=> !st_ff.evt_stat)
    else $error("status not cleared");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == (st_ff.evt_stat && st_ff.evt_mask))
    else $error("interrupt level wrong");

  // Run control and clear
  run_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_write_s |=> st_ff.state == IFC_ST_COUNT && st_ff.count_run_control)
    else $error("counter did not start");

  run_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_write_s |=> st_ff.state == IFC_ST_IDLE)
    else $error("counter did not stop");

  run_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.count_run_control == (st_ff.state == IFC_ST_COUNT))
    else $error("run bit disagrees with counter state");

  count_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && addr == IFC_MODE_OFS && wdata[IFC_CLR_BIT] |=> st_ff.count == '0)
    else $error("count not cleared");

  mode_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_read_s |=> rdata[IFC_CLR_BIT:IFC_RSVD_BIT] == 2'h0)
    else $error("clear or reserved bit reads one");

  // Gate and input selection
  gate_sel_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && addr == IFC_MODE_OFS |=> st_ff.gate_sel == $past(wdata[IFC_GATE_LSB +: 2]))
    else $error("gate field not stored");

  gate_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gate_end |-> st_ff.gate_sel != 2'h3 && st_ff.gate_cnt + 32'h1 == (st_ff.gate_sel == 2'h0 ?
    GATE8_CYC : (st_ff.gate_sel == 2'h1 ? GATE32_CYC : GATE128_CYC)))
    else $error("gate ended at wrong length");

  gate_timer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.state == IFC_ST_COUNT && !gate_end && !wr |=> st_ff.gate_cnt == $past(st_ff.gate_cnt) + 32'h1)
    else $error("gate timer stalled");

  input_sel_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && addr == IFC_MODE_OFS |=> st_ff.input_sel == $past(wdata[IFC_INSEL_LSB +: 2]))
    else $error("input field not stored");

  pin_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_ff.input_sel[1] && !wr |=> st_ff.count == $past(st_ff.count))
    else $error("disabled input counted");

  // Count readback
  read_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd && addr == IFC_CNT_LOW_OFS |=> rdata == $past(st_ff.count[7:0]))
    else $error("low count byte wrong");

  read_mid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd && addr == IFC_CNT_MID_OFS |=> rdata == $past(st_ff.count[15:8]))
    else $error("middle count byte wrong");

  read_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd && addr == IFC_CNT_HIGH_OFS |=> rdata[2:0] == $past(st_ff.count[18:16]) && rdata[7:4] == 4'h0)
    else $error("top count bits wrong");

  det_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sel_rise |=> st_ff.detect_status_bit)
    else $error("edge not marked in detect bit");

  // Counting interval
  edge_inc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.state == IFC_ST_COUNT && sel_rise && !wr |=> st_ff.count == $past(st_ff.count) + 19'h1)
    else $error("edge not counted");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.state == IFC_ST_IDLE && !wr |=> st_ff.count == $past(st_ff.count))
    else $error("count moved while stopped");

  stop_on_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gate_end && !wr |=> st_ff.state == IFC_ST_IDLE && !st_ff.count_run_control)
    else $error("counter ran past gate end");

  soft_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_stop_s |=> st_ff.count_done_flag && st_ff.state == IFC_ST_IDLE)
    else $error("software gate stop not recorded");
endmodule : ifc_counter
`default_nettype wire

/* File: src/ifc_pkg.sv */
// Package of constants and types for the IF frequency counter
`default_nettype none
package ifc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IFC_MODE_OFS = 8'hf4;
  localparam logic [7:0] IFC_CNT_HIGH_OFS = 8'hf5;
  localparam logic [7:0] IFC_CNT_MID_OFS = 8'hf6;
  localparam logic [7:0] IFC_CNT_LOW_OFS = 8'hf7;
  localparam logic [7:0] IFC_IRQ_STAT_OFS = 8'hf8;
  localparam logic [7:0] IFC_IRQ_MASK_OFS = 8'hf9;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IFC_DONE_BIT = 7;
  localparam int IFC_RUN_BIT = 6;
  localparam int IFC_CLR_BIT = 5;
  localparam int IFC_RSVD_BIT = 4;
  localparam int IFC_GATE_LSB = 2;
  localparam int IFC_INSEL_LSB = 0;
  localparam int IFC_CNT_W = 19;
  localparam int IFC_DET_BIT = 3;
  localparam int IFC_EVT_DONE_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IFC_MODE_RST = 8'h00;
  localparam logic [7:0] IFC_MASK_RST = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int IFC_CLK_MHZ = 200;
  localparam int IFC_GATE8_MS = 8;
  localparam int IFC_GATE32_MS = 32;
  localparam int IFC_GATE128_MS = 128;
  localparam logic [31:0] IFC_GATE8_CYC = 32'(IFC_GATE8_MS * IFC_CLK_MHZ * 1000);
  localparam logic [31:0] IFC_GATE32_CYC = 32'(IFC_GATE32_MS * IFC_CLK_MHZ * 1000);
  localparam logic [31:0] IFC_GATE128_CYC = 32'(IFC_GATE128_MS * IFC_CLK_MHZ * 1000);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    IFC_GATE_8MS = 2'h0,
    IFC_GATE_32MS = 2'h1,
    IFC_GATE_128MS = 2'h2,
    IFC_GATE_SOFT = 2'h3
  } ifc_gate_t;
  typedef enum logic [1:0]
  {
    IFC_ST_IDLE = 2'h0,
    IFC_ST_COUNT = 2'h1
  } ifc_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ifc_bus_req_t;
endpackage : ifc_pkg
`default_nettype wire

/* File: src/ifc_sync.sv */
// Two-flop synchroniser with rising-edge detect for one pin
`default_nettype none
module ifc_sync
  import ifc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic rise
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } ifc_sync_st_t;
  ifc_sync_st_t st_ff;
  ifc_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Edge detect reads only the second and third stages
  assign rise = st_ff.sync & ~st_ff.last;
endmodule : ifc_sync
`default_nettype wire

/* File: sim/ifc_if_source.sv */
// Model of the FM and AM IF signal sources feeding the counter pins
`default_nettype none
module ifc_if_source
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic on_am,
  input wire logic [15:0] n_pulse,
  output logic busy,
  output logic fm_if_input_pin,
  output logic am_if_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_ff;
  logic [1:0] ph_ff;
  logic am_ff;
  // Two cycles high, two low: slow enough for the pin synchroniser to see every edge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_ff <= 16'h0000;
      ph_ff <= 2'h0;
      am_ff <= 1'b0;
    end
    else if (go)
    begin
      left_ff <= n_pulse;
      ph_ff <= 2'h0;
      am_ff <= on_am;
    end
    else if (left_ff != 16'h0000)
    begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h3)
        left_ff <= left_ff - 16'h0001;
    end
  end
  assign busy = (left_ff != 16'h0000);
  // Idle pins are held low, as a quiet IF source would leave them
  assign fm_if_input_pin = busy & ~ph_ff[1] & ~am_ff;
  assign am_if_input_pin = busy & ~ph_ff[1] & am_ff;
endmodule : ifc_if_source
`default_nettype wire

/* File: sim/tb_if_frequency_counter.sv */
// Testbench of the IF frequency counter
`default_nettype none
module tb_if_frequency_counter
  import ifc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GCYC [3] = '{100, 200, 400};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic isr_start = 1'b0;
  logic [7:0] rdata;
  logic irq;
  wire logic fm_pin;
  wire logic am_pin;
  logic src_go = 1'b0;
  logic src_am = 1'b0;
  logic [15:0] src_n = 16'h0000;
  logic src_busy;
  int n_mismatch = 0;
  int cmp_count = 0;
  int c;
  logic [7:0] ofs [7] = '{8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'h10};

  ifc_counter #(.GATE8_CYC(32'd100), .GATE32_CYC(32'd200), .GATE128_CYC(32'd400)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fm_if_input_pin(fm_pin), .am_if_input_pin(am_pin),
    .isr_start(isr_start), .irq(irq));
  ifc_if_source src (.ref_clk(ref_clk), .rst_n(rst_n), .go(src_go), .on_am(src_am),
    .n_pulse(src_n), .busy(src_busy), .fm_if_input_pin(fm_pin), .am_if_input_pin(am_pin));

  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Callers never set the reserved mode bit
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic pulses(input logic on_am, input logic [15:0] n);
    int i;
    @(posedge ref_clk);
    src_am <= on_am;
    src_n <= n;
    src_go <= 1'b1;
    @(posedge ref_clk);
    src_go <= 1'b0;
    for (i = 0; i < 5000; i++)
    begin
      @(posedge ref_clk);
      if (src_busy === 1'b0)
        break;
    end
    if (i == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
    // Let the last edge through the synchroniser
    repeat (5) @(posedge ref_clk);
  endtask : pulses

  // Soft-gated run: clear, start, burst on one pin, stop
  task automatic soft_run(input logic [1:0] sel, input logic on_am, input logic [15:0] n);
    wr_reg(IFC_MODE_OFS, 8'h2c | sel);
    wr_reg(IFC_MODE_OFS, 8'h4c | sel);
    pulses(on_am, n);
    wr_reg(IFC_MODE_OFS, 8'h0c | sel);
  endtask : soft_run

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ofs[i])
      rd_chk(ofs[i], 8'h00);
    check("irq", irq, 1'b0);
    $display("Test reset values done");
    wr_reg(IFC_IRQ_MASK_OFS, 8'h01);
    wr_reg(IFC_MODE_OFS, 8'h2e);
    wr_reg(IFC_MODE_OFS, 8'h4e);
    pulses(1'b1, 16'd3);
    pulses(1'b0, 16'd5);
    wr_reg(IFC_MODE_OFS, 8'h0e);
    settle(3);
    check("irq", irq, 1'b1);
    rd_chk(IFC_CNT_LOW_OFS, 8'h05);
    rd_chk(IFC_CNT_MID_OFS, 8'h00);
    rd_chk(IFC_CNT_HIGH_OFS, 8'h08);
    rd_chk(IFC_MODE_OFS, 8'h8e);
    rd_chk(IFC_MODE_OFS, 8'h0e);
    wr_reg(IFC_IRQ_STAT_OFS, 8'h01);
    settle(2);
    check("irq", irq, 1'b0);
    wr_reg(IFC_MODE_OFS, 8'h20);
    rd_chk(IFC_CNT_LOW_OFS, 8'h00);
    $display("Test soft gate done");
    soft_run(2'h0, 1'b0, 16'd4);
    rd_chk(IFC_CNT_LOW_OFS, 8'h00);
    soft_run(2'h1, 1'b1, 16'd4);
    rd_chk(IFC_CNT_LOW_OFS, 8'h00);
    soft_run(2'h3, 1'b1, 16'd7);
    rd_chk(IFC_CNT_LOW_OFS, 8'h07);
    soft_run(2'h3, 1'b0, 16'd2);
    rd_chk(IFC_CNT_LOW_OFS, 8'h00);
    soft_run(2'h2, 1'b0, 16'd300);
    rd_chk(IFC_CNT_MID_OFS, 8'h01);
    rd_chk(IFC_CNT_LOW_OFS, 8'h2c);
    $display("Test input select done");
    wr_reg(IFC_IRQ_STAT_OFS, 8'h01);
    wr_reg(IFC_IRQ_MASK_OFS, 8'h00);
    soft_run(2'h2, 1'b0, 16'd1);
    settle(3);
    check("irq", irq, 1'b0);
    rd_chk(IFC_IRQ_STAT_OFS, 8'h01);
    wr_reg(IFC_IRQ_MASK_OFS, 8'h01);
    settle(3);
    check("irq", irq, 1'b1);
    isr_start <= 1'b1;
    @(posedge ref_clk);
    isr_start <= 1'b0;
    rd_chk(IFC_MODE_OFS, 8'h0e);
    $display("Test interrupt done");
    for (int g = 0; g < 3; g++)
    begin
      wr_reg(IFC_IRQ_STAT_OFS, 8'h01);
      wr_reg(IFC_MODE_OFS, 8'h22 | 8'(g << 2));
      wr_reg(IFC_MODE_OFS, 8'h42 | 8'(g << 2));
      fork
        pulses(1'b0, 16'd3);
        for (c = 0; c < 1000; c++)
        begin
          @(posedge ref_clk);
          if (irq === 1'b1)
            break;
        end
      join
      if (c == 1000)
      begin
        n_mismatch++;
        stop_test();
      end
      check("gate length", 16'(c), 16'(GCYC[g]));
      rd_chk(IFC_CNT_LOW_OFS, 8'h03);
      rd_chk(IFC_MODE_OFS, 8'h82 | 8'(g << 2));
    end
    $display("Test gate times done");
    stop_test();
  end
endmodule : tb_if_frequency_counter
`default_nettype wire
